// [core/mcc_top.sv]
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ns
`include "mcc_params.svh"
module mcc_top (
  input wire logic CLK,
  input wire logic RST,
  input wire mcc_pkg::mcc_avs_req_t AVS_REQ,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output mcc_pkg::mcc_resp_t AVS_RESPONSE,
  input wire logic FREEZE_IN,
  input wire logic BUS_RX,
  input wire logic [15:0] BUFFER_EVENTS,
  output logic CLOCKS_RUN,
  output logic DEBUG_ACTIVE,
  output logic BUFFERS_ACTIVE,
  output logic BIT_TICK,
  output logic WAKE_IRQ,
  output logic SOFT_RESET_ACTIVE,
  output logic [2:0] BUS_CTRL_CFG
);
  import mcc_pkg::*;
  localparam logic [15:0] mcr_rst_val = `MCC_MCR_RST; // Named so single bits can be picked

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic freeze_s;
  logic rx_s;
  logic rx_prev_ff;
  logic stop_ff;
  logic dbg_resp_en_ff;
  logic halt_ff;
  logic wake_irq_en_ff;
  logic priv_only_ff;
  logic act_wake_en_ff;
  logic aps_ff;
  logic unavail_ff;
  logic dbg_ack_ff;
  logic stopack_ff;
  logic presc_en_ff;
  logic wake_pend_ff;
  logic [15:0] icr_ff;
  logic [15:0] tcr_ff;
  logic [15:0] bmask_ff;
  logic [15:0] bflag_ff;
  logic [7:0] pdiv_ff;
  logic [7:0] presc_cnt_ff;
  logic [3:0] sync_cnt_ff;
  mcc_dbg_state_t dbg_ff;
  mcc_dbg_state_t nxt_dbg;
  logic srst_busy;
  logic srst_done;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Word index match, used by every register decode
  function automatic logic sel(input logic [3:0] addr, input logic [3:0] ofs);
    sel = (addr == ofs);
  endfunction

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [15:0] wd,
                                           input logic [1:0] be);
    be_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  mcc_sync #(.W(2)) u_sync (
    .clk(CLK),
    .rst(RST),
    .din({FREEZE_IN, BUS_RX}),
    .dout({freeze_s, rx_s})
  );

  // ----------------------------------------
  // Avalon-MM slave decode
  // ----------------------------------------
  wire req = AVS_REQ.read || AVS_REQ.write;
  wire accept = req && AVS_WAITREQUEST;          // Cycle in which the answer is prepared
  wire commit = req && !AVS_WAITREQUEST;         // Edge at which the master samples
  wire [3:0] addr = AVS_REQ.address;
  wire [15:0] wd = AVS_REQ.writedata[15:0];
  wire [1:0] be = AVS_REQ.byteenable[1:0];
  wire hit_mcr = sel(addr, `MCC_OFS_MCR);
  wire hit_icr = sel(addr, `MCC_OFS_ICR);
  wire hit_tcr = sel(addr, `MCC_OFS_TCR);
  wire hit_bmask = sel(addr, `MCC_OFS_BMASK);
  wire hit_bflag = sel(addr, `MCC_OFS_BFLAG);
  wire hit_ctrl = sel(addr, `MCC_OFS_CTRL);
  wire hit_pdiv = sel(addr, `MCC_OFS_PDIV);
  wire hit_wstat = sel(addr, `MCC_OFS_WSTAT);
  wire hit_any = hit_mcr || hit_icr || hit_tcr || hit_bmask || hit_bflag || hit_ctrl ||
                 hit_pdiv || hit_wstat;
  wire priv_ok = !priv_only_ff || AVS_REQ.supervisor;
  wire acc_ok = hit_any && priv_ok;
  wire wr_go = commit && AVS_REQ.write && acc_ok;
  wire mcr_wr = wr_go && hit_mcr;
  wire hi_wr = mcr_wr && be[1];
  wire lo_wr = mcr_wr && be[0];

  // ----------------------------------------
  // Soft reset
  // ----------------------------------------
  // self-clearing trigger
  wire srst_start = hi_wr && wd[`MCC_BIT_SWRST];

  mcc_srst_seq u_srst (
    .clk(CLK),
    .rst(RST),
    .start(srst_start),
    .busy(srst_busy),
    .done(srst_done)
  );

  // Host registers go back to reset when the internal cycle ends; bus
  // control and divider keep their values so a running bus is not upset.
  // host register reset
  wire host_clr = srst_done;

  // ----------------------------------------
  // Mode requests and wake detection
  // ----------------------------------------
  // hold acts as freeze
  wire freeze_src = freeze_s || halt_ff;
  wire freeze_req = dbg_resp_en_ff && freeze_src;
  wire rx_fall = rx_prev_ff && !rx_s;            // Recessive to dominant
  wire wake_hit = stop_ff && act_wake_en_ff && rx_fall;
  // A stop write racing a bus edge with self-wake set does not take
  wire wr_act_wake = lo_wr ? wd[`MCC_BIT_ACTWAKE] : act_wake_en_ff;
  wire stop_race = wr_act_wake && rx_fall;
  wire stop_set = hi_wr && wd[`MCC_BIT_STOP] && !stop_race && !srst_start;

  // ----------------------------------------
  // Stop request bit
  // ----------------------------------------
  // set by CPU only, cleared by CPU, wake or soft reset
  wire nxt_stop = (host_clr || srst_start || wake_hit) ? 1'b0 :
                  hi_wr ? stop_set : stop_ff;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      stop_ff <= mcr_rst_val[`MCC_BIT_STOP];
      stopack_ff <= mcr_rst_val[`MCC_BIT_STOPACK];
      CLOCKS_RUN <= 1'b1;
    end else begin
      stop_ff <= nxt_stop;
      stopack_ff <= stop_ff;                       // Acknowledge once clocks are off
      CLOCKS_RUN <= !nxt_stop;
    end
  end

  // ----------------------------------------
  // Configuration register writable fields
  // ----------------------------------------
  // hold comes up set
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      dbg_resp_en_ff <= mcr_rst_val[`MCC_BIT_DBGEN];
      halt_ff <= mcr_rst_val[`MCC_BIT_HALT];
      wake_irq_en_ff <= mcr_rst_val[`MCC_BIT_WAKEIE];
      priv_only_ff <= mcr_rst_val[`MCC_BIT_PRIV];
      act_wake_en_ff <= mcr_rst_val[`MCC_BIT_ACTWAKE];
      aps_ff <= mcr_rst_val[`MCC_BIT_APS];
    end else if (host_clr) begin
      dbg_resp_en_ff <= mcr_rst_val[`MCC_BIT_DBGEN];
      halt_ff <= mcr_rst_val[`MCC_BIT_HALT];
      wake_irq_en_ff <= mcr_rst_val[`MCC_BIT_WAKEIE];
      priv_only_ff <= mcr_rst_val[`MCC_BIT_PRIV];
      act_wake_en_ff <= mcr_rst_val[`MCC_BIT_ACTWAKE];
      aps_ff <= mcr_rst_val[`MCC_BIT_APS];
    end else begin
      if (hi_wr) begin
        dbg_resp_en_ff <= wd[`MCC_BIT_DBGEN];
        halt_ff <= wd[`MCC_BIT_HALT];
        wake_irq_en_ff <= wd[`MCC_BIT_WAKEIE];
      end
      if (lo_wr) begin
        priv_only_ff <= wd[`MCC_BIT_PRIV];
        act_wake_en_ff <= wd[`MCC_BIT_ACTWAKE];
        aps_ff <= wd[`MCC_BIT_APS];
      end
    end
  end

  // ----------------------------------------
  // Debug sequence
  // ----------------------------------------
  // prescaler off before ack, back on before ack drops
  always_comb begin
    nxt_dbg = dbg_ff;
    case (dbg_ff)
      MCC_DBG_RUN: begin
        if (freeze_req) begin
          nxt_dbg = MCC_DBG_HALTING;
        end
      end
      MCC_DBG_HALTING: begin
        nxt_dbg = MCC_DBG_FROZEN;
      end
      MCC_DBG_FROZEN: begin
        // leave when enable or source drops
        if (!freeze_req) begin
          nxt_dbg = MCC_DBG_RESUMING;
        end
      end
      MCC_DBG_RESUMING: begin
        nxt_dbg = MCC_DBG_RUN;
      end
      default: begin
        nxt_dbg = MCC_DBG_RUN;
      end
    endcase
  end

  wire dbg_enter = (dbg_ff == MCC_DBG_RUN) && freeze_req;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      dbg_ff <= MCC_DBG_RUN;
      presc_en_ff <= 1'b1;
      dbg_ack_ff <= 1'b0;
      DEBUG_ACTIVE <= 1'b0;
    end else begin
      dbg_ff <= nxt_dbg;
      presc_en_ff <= (nxt_dbg == MCC_DBG_RUN) || (nxt_dbg == MCC_DBG_RESUMING);
      dbg_ack_ff <= (nxt_dbg == MCC_DBG_FROZEN) || (nxt_dbg == MCC_DBG_RESUMING);
      DEBUG_ACTIVE <= nxt_dbg != MCC_DBG_RUN;
    end
  end

  // ----------------------------------------
  // Not-ready flag and bus synchronisation
  // ----------------------------------------
  // Sync needs a run of recessive samples after both modes are left;
  // a dominant sample restarts the count.
  wire modes_off = !stop_ff && (dbg_ff == MCC_DBG_RUN) && !freeze_req;
  wire sync_done = sync_cnt_ff == 4'(`MCC_SYNC_BITS - 1);
  wire [3:0] nxt_sync = (unavail_ff && modes_off && rx_s) ? sync_cnt_ff + 4'h1 : 4'h0;
  wire unavail_set = dbg_enter || stop_set;
  wire unavail_clr = (modes_off && rx_s && sync_done) || (wake_hit && dbg_ff == MCC_DBG_RUN);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      unavail_ff <= mcr_rst_val[`MCC_BIT_UNAVAIL];
      sync_cnt_ff <= 4'h0;
      rx_prev_ff <= 1'b0;                        // Same as synchroniser reset: no false edge
    end else begin
      unavail_ff <= unavail_set || (unavail_ff && !unavail_clr);
      sync_cnt_ff <= unavail_clr ? 4'h0 : nxt_sync;
      rx_prev_ff <= rx_s;
    end
  end

  // ----------------------------------------
  // Bit prescaler
  // ----------------------------------------
  wire presc_run = presc_en_ff && !stop_ff;
  wire presc_wrap = presc_cnt_ff == pdiv_ff;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      presc_cnt_ff <= 8'h00;
      BIT_TICK <= 1'b0;
    end else begin
      presc_cnt_ff <= (!presc_run || presc_wrap) ? 8'h00 : presc_cnt_ff + 8'h01;
      BIT_TICK <= presc_run && presc_wrap;
    end
  end

  // ----------------------------------------
  // Buffer activity and wake interrupt
  // ----------------------------------------
  // buffers idle while held
  wire buf_ok = !halt_ff && (dbg_ff == MCC_DBG_RUN) && !stop_ff && !unavail_ff;
  wire wake_w1c = wr_go && hit_wstat && be[0] && wd[0];

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wake_pend_ff <= 1'b0;
      WAKE_IRQ <= 1'b0;
      BUFFERS_ACTIVE <= 1'b0;
      SOFT_RESET_ACTIVE <= 1'b0;
    end else begin
      // Set wins over a clear in the same cycle
      wake_pend_ff <= wake_hit || (wake_pend_ff && !wake_w1c);
      WAKE_IRQ <= wake_irq_en_ff && (wake_hit || (wake_pend_ff && !wake_w1c));
      BUFFERS_ACTIVE <= buf_ok;
      SOFT_RESET_ACTIVE <= srst_start || (srst_busy && !srst_done);
    end
  end

  // ----------------------------------------
  // Host interface registers
  // ----------------------------------------
  // test register and direct flag writes only while held
  wire tcr_wr = wr_go && hit_tcr && halt_ff;
  wire [15:0] bflag_clr = (wr_go && hit_bflag && !halt_ff) ? be_merge(16'h0000, wd, be) : 16'h0;
  wire bflag_load = wr_go && hit_bflag && halt_ff;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      icr_ff <= `MCC_ICR_RST;
      tcr_ff <= `MCC_ZERO16;
      bmask_ff <= `MCC_ZERO16;
      bflag_ff <= `MCC_ZERO16;
    end else if (host_clr) begin
      icr_ff <= `MCC_ICR_RST;
      tcr_ff <= `MCC_ZERO16;
      bmask_ff <= `MCC_ZERO16;
      bflag_ff <= `MCC_ZERO16;
    end else begin
      if (wr_go && hit_icr) begin
        icr_ff <= be_merge(icr_ff, wd, be);
      end
      if (tcr_wr) begin
        tcr_ff <= be_merge(tcr_ff, wd, be);
      end
      if (wr_go && hit_bmask) begin
        bmask_ff <= be_merge(bmask_ff, wd, be);
      end
      // Buffer events win over a clear in the same cycle
      bflag_ff <= (bflag_load ? be_merge(bflag_ff, wd, be) : (bflag_ff & ~bflag_clr)) |
                  BUFFER_EVENTS;
    end
  end

  // bus control and divider survive soft reset
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      BUS_CTRL_CFG <= `MCC_CTRL_RST;
      pdiv_ff <= `MCC_PDIV_RST;
    end else begin
      if (wr_go && hit_ctrl && be[0]) begin
        BUS_CTRL_CFG <= wd[2:0];
      end
      if (wr_go && hit_pdiv && be[0]) begin
        pdiv_ff <= wd[7:0];
      end
    end
  end

  // ----------------------------------------
  // Read data selection
  // ----------------------------------------
  // reserved and unused bits read zero
  wire [15:0] mcr_view = {stop_ff, dbg_resp_en_ff, 1'b0, halt_ff, unavail_ff,
                          wake_irq_en_ff, srst_busy || SOFT_RESET_ACTIVE, dbg_ack_ff,
                          priv_only_ff, act_wake_en_ff, aps_ff, stopack_ff, 4'h0};
  wire [15:0] rd_mux = ({16{hit_mcr}} & mcr_view) |
                       ({16{hit_icr}} & icr_ff) |
                       ({16{hit_tcr}} & tcr_ff) |
                       ({16{hit_bmask}} & bmask_ff) |
                       ({16{hit_bflag}} & bflag_ff) |
                       ({16{hit_ctrl}} & {13'h0, BUS_CTRL_CFG}) |
                       ({16{hit_pdiv}} & {8'h00, pdiv_ff}) |
                       ({16{hit_wstat}} & {15'h0, wake_pend_ff});
  wire mcc_resp_t resp_sel = !hit_any ? MCC_RESP_DECERR :
                             !priv_ok ? MCC_RESP_SLVERR : MCC_RESP_OKAY;

  // ----------------------------------------
  // Bus answer: one wait cycle, then a single ready cycle
  // ----------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h00000000;
      AVS_RESPONSE <= MCC_RESP_OKAY;
    end else begin
      AVS_WAITREQUEST <= !accept;
      if (accept) begin
        AVS_READDATA <= (AVS_REQ.read && acc_ok) ? {16'h0000, rd_mux} : 32'h00000000;
        AVS_RESPONSE <= resp_sel;
      end
    end
  end
endmodule

// [core/mcc_params.svh]
`ifndef MCC_PARAMS_SVH
`define MCC_PARAMS_SVH

// ----------------------------------------
// Register word indexes (byte address = 4 * index)
// ----------------------------------------
`define MCC_OFS_MCR 4'h0
`define MCC_OFS_ICR 4'h1
`define MCC_OFS_TCR 4'h2
`define MCC_OFS_BMASK 4'h3
`define MCC_OFS_BFLAG 4'h4
`define MCC_OFS_CTRL 4'h5
`define MCC_OFS_PDIV 4'h6
`define MCC_OFS_WSTAT 4'h7

// ----------------------------------------
// Configuration register fields (LSB-0 numbering)
// ----------------------------------------
`define MCC_BIT_STOP 15
`define MCC_BIT_DBGEN 14
`define MCC_BIT_HALT 12
`define MCC_BIT_UNAVAIL 11
`define MCC_BIT_WAKEIE 10
`define MCC_BIT_SWRST 9
`define MCC_BIT_DBGACK 8
`define MCC_BIT_PRIV 7
`define MCC_BIT_ACTWAKE 6
`define MCC_BIT_APS 5
`define MCC_BIT_STOPACK 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MCC_MCR_RST 16'h5980
`define MCC_ICR_RST 16'h000F
`define MCC_ZERO16 16'h0000
`define MCC_CTRL_RST 3'h0
`define MCC_PDIV_RST 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define MCC_CLK_PERIOD_NS 10
`define MCC_SRST_TIME_NS 40
`define MCC_SRST_CYCLES ((`MCC_SRST_TIME_NS + `MCC_CLK_PERIOD_NS - 1) / `MCC_CLK_PERIOD_NS)
`define MCC_SYNC_BITS 11

`endif

// [core/mcc_pkg.sv]
package mcc_pkg;
  // Avalon-MM request group, driven by the bus master
  typedef struct packed {
    logic read;
    logic write;
    logic supervisor;
    logic [3:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } mcc_avs_req_t;

  // Debug entry and exit sequence
  typedef enum logic [3:0] {
    MCC_DBG_RUN = 4'h1,
    MCC_DBG_HALTING = 4'h2,
    MCC_DBG_FROZEN = 4'h4,
    MCC_DBG_RESUMING = 4'h8
  } mcc_dbg_state_t;

  // Avalon-MM response codes
  typedef enum logic [1:0] {
    MCC_RESP_OKAY = 2'h0,
    MCC_RESP_SLVERR = 2'h2,
    MCC_RESP_DECERR = 2'h3
  } mcc_resp_t;
endpackage

// [core/mcc_sync.sv]
`timescale 1ns/1ns
module mcc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_ff;

  // ----------------------------------------
  // Two-stage synchroniser, first stage read only by the second
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      dout <= '0;
    end else begin
      meta_ff <= din;
      dout <= meta_ff;
    end
  end
endmodule

// [core/mcc_srst_seq.sv]
`timescale 1ns/1ns
`include "mcc_params.svh"
module mcc_srst_seq (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  output logic busy,
  output logic done
);
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic last;

  // Last cycle of the internal reset interval
  assign last = busy && (cnt_ff == 3'(`MCC_SRST_CYCLES - 1));
  assign nxt_cnt = busy ? cnt_ff + 3'h1 : 3'h0;

  // ----------------------------------------
  // Soft reset interval counter
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt_ff <= 3'h0;
    end else begin
      // A retrigger while busy is absorbed into the running cycle; one in its last cycle starts a new cycle
      busy <= (busy && !last) || start;
      done <= last;
      cnt_ff <= last ? 3'h0 : nxt_cnt;
    end
  end
endmodule

// [verif/mcc_link_model.sv]
`timescale 1ns/1ns
// ----------------------------------------
// Far side: freeze line and bus receive line
// ----------------------------------------
module mcc_link_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic freeze_cmd,
  input wire logic wake_cmd,
  output logic freeze_line,
  output logic bus_line
);
  logic [2:0] dom_ff;
  logic freeze_ff;
  // Bus rests recessive; a wake request sends a short dominant burst
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dom_ff <= 3'h0;
      freeze_ff <= 1'b0;
    end else begin
      dom_ff <= wake_cmd ? 3'h5 : (dom_ff != 3'h0 ? dom_ff - 3'h1 : 3'h0);
      freeze_ff <= freeze_cmd;
    end
  end
  // Recessive is the pulled-up level, so an idle bus reads 1
  assign bus_line = (dom_ff == 3'h0);
  assign freeze_line = freeze_ff;
endmodule

// [verif/mcc_top_sva.sv]
`timescale 1ns/1ns
module mcc_chk (
  input wire logic CLK,
  input wire logic RST,
  input wire mcc_pkg::mcc_avs_req_t AVS_REQ,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire mcc_pkg::mcc_resp_t AVS_RESPONSE,
  input wire logic CLOCKS_RUN,
  input wire logic DEBUG_ACTIVE,
  input wire logic BUFFERS_ACTIVE,
  input wire logic BIT_TICK,
  input wire logic SOFT_RESET_ACTIVE
);
  import mcc_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  // Request seen while the slave still waits
  sequence s_taken;
    (AVS_REQ.read || AVS_REQ.write) && AVS_WAITREQUEST;
  endsequence
  sequence s_unmapped;
    s_taken ##0 AVS_REQ.address[3];
  endsequence
  sequence s_cfg_read;
    s_taken ##0 (AVS_REQ.read && AVS_REQ.address == 4'h0);
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_ANSWER: assert property (s_taken |=> !AVS_WAITREQUEST)
    else $error("request not answered after one wait cycle");
  AST_ONE_READY: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("ready held longer than one cycle");
  AST_UNMAPPED: assert property (s_unmapped |=>
    AVS_RESPONSE == MCC_RESP_DECERR && AVS_READDATA == 32'h0)
    else $error("unmapped access not refused");
  AST_RSVD_ZERO: assert property (
    s_cfg_read |=> AVS_RESPONSE != MCC_RESP_OKAY || !AVS_READDATA[13])
    else $error("reserved bit reads one");
  AST_STOP_BY_WRITE: assert property (
    $fell(CLOCKS_RUN) |-> $past(AVS_REQ.write) || $past(AVS_REQ.write, 2)
    || $past(AVS_REQ.write, 3))
    else $error("clocks stopped without a write");
  AST_SRST_STOP: assert property ($rose(SOFT_RESET_ACTIVE) |-> ##[0:2] CLOCKS_RUN)
    else $error("soft reset left clocks stopped");
  AST_SRST_END: assert property (
    $rose(SOFT_RESET_ACTIVE) |-> SOFT_RESET_ACTIVE [*2] ##[1:6] !SOFT_RESET_ACTIVE)
    else $error("soft reset did not finish in time");
  AST_PRESC_HALT: assert property ($rose(DEBUG_ACTIVE) |-> ##2 !BIT_TICK)
    else $error("prescaler ticks in debug entry");
  AST_BUF_IDLE: assert property (DEBUG_ACTIVE [*2] |-> !BUFFERS_ACTIVE)
    else $error("buffers active in debug mode");
endmodule

bind mcc_top mcc_chk u_chk (.CLK(CLK), .RST(RST), .AVS_REQ(AVS_REQ),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .AVS_RESPONSE(AVS_RESPONSE), .CLOCKS_RUN(CLOCKS_RUN), .DEBUG_ACTIVE(DEBUG_ACTIVE),
  .BUFFERS_ACTIVE(BUFFERS_ACTIVE), .BIT_TICK(BIT_TICK),
  .SOFT_RESET_ACTIVE(SOFT_RESET_ACTIVE));

// [verif/mcc_top_tb.sv]
`timescale 1ns/1ns
module mcc_top_tb;
  import mcc_pkg::*;
  logic clk, rst, freeze_cmd, wake_cmd, freeze_line, bus_line, waitreq, usr;
  logic clocks_run, debug_active, buffers_active, bit_tick, wake_irq, srst_active;
  logic [15:0] buf_ev, v, w;
  logic [31:0] av_rd, rd;
  logic [2:0] ctrl_cfg, cv;
  logic [7:0] pv;
  mcc_avs_req_t req;
  mcc_resp_t av_rs, rs;
  int n_mismatch, tests_run, i;

  mcc_top DUT (.CLK(clk), .RST(rst), .AVS_REQ(req), .AVS_READDATA(av_rd),
    .AVS_WAITREQUEST(waitreq), .AVS_RESPONSE(av_rs), .FREEZE_IN(freeze_line),
    .BUS_RX(bus_line), .BUFFER_EVENTS(buf_ev), .CLOCKS_RUN(clocks_run),
    .DEBUG_ACTIVE(debug_active), .BUFFERS_ACTIVE(buffers_active), .BIT_TICK(bit_tick),
    .WAKE_IRQ(wake_irq), .SOFT_RESET_ACTIVE(srst_active), .BUS_CTRL_CFG(ctrl_cfg));
  mcc_link_model u_link (.clk(clk), .rst(rst), .freeze_cmd(freeze_cmd),
    .wake_cmd(wake_cmd), .freeze_line(freeze_line), .bus_line(bus_line));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  // One Avalon transfer; request held until ready is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
    int k;
    @(posedge clk);
    req <= {!wr, wr, !usr, a, 16'h0000, d, 4'h3};
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (waitreq === 1'b0) break;
    end
    rd = av_rd;
    rs = av_rs;
    req <= '0;
    if (k == 20) begin
      n_mismatch++;
      tally_and_finish;
    end
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [15:0] e, input string nm);
    bus(1'b0, a, 16'h0000);
    chk(nm, {16'h0000, e}, rd);
  endtask
  // Polls the configuration register until one bit shows the wanted level
  task automatic poll(input int b, input logic val);
    int k;
    for (k = 0; k < 60; k++) begin
      bus(1'b0, 4'h0, 16'h0000);
      if (rd[b] === val) break;
    end
    chk1("polled bit", val, rd[b]);
    if (k == 60) tally_and_finish;
  endtask
  task automatic wait_srst(input logic val);
    int k;
    for (k = 0; k < 40 && srst_active !== val; k++) @(posedge clk);
    chk1("soft reset busy", val, srst_active);
    if (k == 40) tally_and_finish;
  endtask
  task automatic pulse_wake;
    wake_cmd <= 1'b1;
    @(posedge clk);
    wake_cmd <= 1'b0;
  endtask
  // Stored configuration fields: stop, enable, hold, wake mask, privilege, wake, power save
  function automatic logic [15:0] mcr_exp(input logic [15:0] wv);
    return wv & 16'hD4E0;
  endfunction

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    tally_and_finish;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    req = '0;
    freeze_cmd = 1'b0;
    usr = 1'b0;
    wake_cmd = 1'b0;
    buf_ev = 16'h0000;
    n_mismatch = 0;
    tests_run = 0;
    void'($urandom(96));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    rdchk(4'h0, 16'h5980, "cfg reset");
    chk1("debug from hold", 1'b1, debug_active);
    chk1("buffers held", 1'b0, buffers_active);
    usr = 1'b1;
    rdchk(4'h0, 16'h0000, "user data");
    chk("user refused", {30'h0, MCC_RESP_SLVERR}, {30'h0, rs});
    usr = 1'b0;
    rdchk(4'h9, 16'h0000, "unmapped data");
    chk("unmapped resp", {30'h0, MCC_RESP_DECERR}, {30'h0, rs});
    v = 16'($urandom);
    cv = 3'($urandom);
    pv = 8'($urandom % 4);
    bus(1'b1, 4'h2, v);
    rdchk(4'h2, v, "test reg in hold");
    bus(1'b1, 4'h5, {13'h0000, cv});
    bus(1'b1, 4'h6, {8'h00, pv});
    bus(1'b1, 4'h1, 16'h0005);
    bus(1'b1, 4'h0, 16'h4080);
    poll(8, 1'b0);
    poll(11, 1'b0);
    rdchk(4'h0, 16'h4080, "cfg running");
    chk1("buffers running", 1'b1, buffers_active);
    bus(1'b1, 4'h2, ~v);
    rdchk(4'h2, v, "test reg locked");
    freeze_cmd <= 1'b1;
    poll(8, 1'b1);
    rdchk(4'h0, 16'h4980, "cfg frozen");
    bus(1'b1, 4'h0, 16'h0080);
    poll(8, 1'b0);
    repeat (20) @(posedge clk);
    chk1("freeze ignored", 1'b0, debug_active);
    bus(1'b1, 4'h0, 16'h1080);
    repeat (20) @(posedge clk);
    chk1("hold ignored", 1'b0, debug_active);
    freeze_cmd <= 1'b0;
    bus(1'b1, 4'h0, 16'h5080);
    poll(8, 1'b1);
    bus(1'b1, 4'h0, 16'h0080);
    poll(8, 1'b0);
    poll(11, 1'b0);
    for (i = 0; i < 6; i++) begin
      w = (16'($urandom) & 16'h2460) | 16'h0080;
      bus(1'b1, 4'h0, w);
      rdchk(4'h0, mcr_exp(w), "cfg fields");
    end
    bus(1'b1, 4'h0, 16'h0000);
    usr = 1'b1;
    rdchk(4'h0, 16'h0000, "user read");
    chk("user allowed", {30'h0, MCC_RESP_OKAY}, {30'h0, rs});
    usr = 1'b0;
    // Stop then self-wake, once without and once with the wake interrupt
    for (i = 0; i < 2; i++) begin
      w = 16'h80C0 | {5'h00, i[0], 10'h000};
      bus(1'b1, 4'h0, w);
      repeat (2) @(posedge clk);
      chk1("clocks stopped", 1'b0, clocks_run);
      rdchk(4'h0, w | 16'h0810, "cfg stopped");
      pulse_wake;
      poll(15, 1'b0);
      chk1("clocks restarted", 1'b1, clocks_run);
      rdchk(4'h0, w & 16'h7FFF, "cfg woken");
      chk1("wake irq", i[0], wake_irq);
      bus(1'b1, 4'h7, 16'h0001);
      @(posedge clk);
      chk1("wake irq cleared", 1'b0, wake_irq);
    end
    bus(1'b1, 4'h0, 16'h8080);
    pulse_wake;
    repeat (10) @(posedge clk);
    chk1("no wake without enable", 1'b0, clocks_run);
    buf_ev <= 16'($urandom);
    @(posedge clk);
    buf_ev <= 16'h0000;
    bus(1'b1, 4'h0, 16'h8280);
    wait_srst(1'b1);
    chk1("soft reset restarts clocks", 1'b1, clocks_run);
    wait_srst(1'b0);
    repeat (2) @(posedge clk);
    poll(8, 1'b1);
    rdchk(4'h0, 16'h5980, "cfg after soft reset");
    rdchk(4'h1, 16'h000F, "irq cfg after soft reset");
    rdchk(4'h2, 16'h0000, "test reg after soft reset");
    rdchk(4'h4, 16'h0000, "flags after soft reset");
    rdchk(4'h5, {13'h0000, cv}, "bus ctrl kept");
    rdchk(4'h6, {8'h00, pv}, "divider kept");
    chk("bus ctrl pins", {29'h0, cv}, {29'h0, ctrl_cfg});
    tally_and_finish;
  end
endmodule
